// ### common/scc_pkg.sv
// Purpose: Shared constants for the synthesizer calibration control block
// Assumes: 125 MHz system clock, 4-bit byte address register port
// Notes:   Field positions, reset values and counts live here only
package scc_pkg;
  // Register byte addresses
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_BANK1     = 4'h4;
  localparam logic [3:0]  ADDR_BANK2     = 4'h8;
  localparam logic [3:0]  ADDR_READBACK  = 4'hC;
  // Control register fields
  localparam int          CTL_CE         = 0;
  localparam int          CTL_RELOCK     = 1;
  localparam int          CTL_MODE       = 2;
  localparam int          CTL_FULL_DUPLEX_SELECT      = 3;
  localparam int          CTL_SWCTL      = 4;
  localparam int          CTL_LFCAL      = 5;
  localparam int          CTL_GPO4LOCK   = 6;
  localparam int          CTL_REFDIV_LSB = 7;
  localparam int          CTL_SINGLE     = 10;
  localparam logic [10:0] CTRL_RESET     = 11'h080;
  // Bank fields: integer divide and LO divider exponent
  localparam int          BK_N_LSB       = 0;
  localparam int          BK_DIV_LSB     = 11;
  localparam logic [13:0] BANK_RESET     = 14'h0A00;
  localparam logic [2:0]  LO_OUTPUT_DIVIDER_MIN     = 3'h1;
  localparam logic [2:0]  LO_OUTPUT_DIVIDER_MAX     = 3'h5;
  // Readback fields
  localparam int          RB_BAND_LSB    = 0;
  localparam int          RB_FAIL        = 7;
  localparam int          RB_LOCK        = 8;
  localparam int          RB_OSC_LSB     = 9;
  localparam int          RB_BUSY        = 11;
  localparam int          RB_SLOW        = 12;
  localparam int          RB_CP_LSB      = 13;
  // Band search and oscillator choice
  localparam logic [6:0]  BAND_MIN       = 7'h00;
  localparam logic [6:0]  BAND_MAX       = 7'h7F;
  localparam logic [10:0] N_MID          = 11'h200;
  localparam logic [10:0] N_HIGH         = 11'h300;
  localparam logic [1:0]  OSC_LOW        = 2'h0;
  localparam logic [1:0]  OSC_MID        = 2'h1;
  localparam logic [1:0]  OSC_HIGH       = 2'h2;
  localparam logic [3:0]  SETTLE_TICKS   = 4'h4;
  localparam logic [2:0]  PRESC_LOW      = 3'h2;
  localparam logic [2:0]  PRESC_HIGH     = 3'h4;
  // Charge pump current codes
  localparam logic [5:0]  CP_DEF         = 6'h1F;
  localparam logic [5:0]  CP_MAX         = 6'h3F;
  // Lock time budget
  localparam int          CLK_MHZ        = 125;
  localparam int          LOCK_TIME_US   = 50;
  localparam int          LOCK_WAIT_CYC  = LOCK_TIME_US * CLK_MHZ;
  // Calibration sequencer states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_OSC    = 5'b00010,
    ST_SETTLE = 5'b00100,
    ST_CHECK  = 5'b01000,
    ST_ACQ    = 5'b10000
  } scc_state_e;
endpackage : scc_pkg

// ### common/scc_tick_if.sv
// Purpose: Carries reference divide ratio and comparison tick
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none
interface scc_tick_if;
  logic [2:0] ratio;
  logic       tick;
  modport div  (input ratio, output tick);
  modport user (output ratio, input tick);
endinterface : scc_tick_if
`default_nettype wire

// ### logic/scc_ref_div.sv
// Purpose: Reference divider producing the comparison clock enable
// Assumes: Ratio programmed 1 to 7; zero is treated as 1
// Notes:   Tick is one mclk cycle wide, period equals ratio cycles
`timescale 1ns/100ps
`default_nettype none
module scc_ref_div (
  input  wire logic  mclk_in,
  input  wire logic  reset_n_in,
  scc_tick_if.div    tk
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [2:0] last;

  // Wrap counter; zero ratio would stall, so it acts as 1
  always_comb begin
    last     = (tk.ratio == 3'h0) ? 3'h0 : tk.ratio - 3'h1;
    cnt_nxt  = cnt_r + 3'h1;
    tick_nxt = 1'b0;
    if (cnt_r >= last) begin
      cnt_nxt  = 3'h0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r  <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.tick = tick_r;
endmodule : scc_ref_div
`default_nettype wire

// ### logic/scc_top.sv
// Purpose: Calibration, bank and LO routing control of a frac-N synthesizer
// Assumes: Pins synchronous to mclk_in; comparison clock is an enable
// Notes:   Analog tuning elements are driven by the outputs below
// Notes on behaviour
// - Three oscillators, 128 bands each, LO divider from /2 to /32.
// - Oscillator and band picked automatically from the active bank.
// - Sequence starts on enable rising edge or relock bit write.
// - Band search adds capacitance stepwise; loop acquires only afterwards.
// - Final band value readable in the readback register.
// - Band result 0 or 127 sets the failure flag.
// - Band result 1 to 126 leaves the failure flag clear.
// - Full duplex enables both mixers and feeds LO to both in the dual variant; the single variant keeps mixer two only.
// - LO routing follows mode pin or bit plus full duplex.
// - Optional loop-filter calibration adjusts charge pump current.
// - Two banks; dual variant bank follows mode selection.
// - Single variant uses mixer two and bank two.
// - Output four can show lock; lock also in readback.
// - Lock flag high only while tuning voltage is in window.
// - Sequencer runs on the comparison clock enable.
// - Lock expected within 50 us; overrun is reported.
// - Feedback prescaler set per oscillator; integer divide from the active bank.
// - Enable high also powers up the analog circuits.
// - Active-low reset returns all digital state to startup.
// - Mode low bank one mixer one, high bank two mixer two.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module scc_top #(
  parameter int LOCK_WAIT_CYCLES = scc_pkg::LOCK_WAIT_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        chip_enable_line_in,
  input  wire logic        mode_in,
  input  wire logic        osc_above_target_in,
  input  wire logic        lock_window_in,
  output logic             analog_power_up_out,
  output logic      [2:0]  osc_sel_out,
  output logic      [6:0]  band_out,
  output logic             band_search_out,
  output logic             loop_acquire_out,
  output logic      [2:0]  lo_output_divider_out,
  output logic      [2:0]  prescaler_div_out,
  output logic      [10:0] n_int_out,
  output logic      [5:0]  cp_current_out,
  output logic             mixer1_en_out,
  output logic             mixer2_en_out,
  output logic             bank_two_sel_out,
  output logic             general_output_four_out,
  output logic             lock_flag_out
);
  import scc_pkg::*;

  // Bank field decode, used for both banks
  function automatic logic [10:0] bank_n(input logic [13:0] b);
    bank_n = b[BK_N_LSB +: 11];
  endfunction : bank_n

  function automatic logic [2:0] bank_div(input logic [13:0] b);
    logic [2:0] d;
    d = b[BK_DIV_LSB +: 3];
    if (d < LO_OUTPUT_DIVIDER_MIN)      bank_div = LO_OUTPUT_DIVIDER_MIN;
    else if (d > LO_OUTPUT_DIVIDER_MAX) bank_div = LO_OUTPUT_DIVIDER_MAX;
    else                     bank_div = d;
  endfunction : bank_div

  scc_tick_if tk ();

  logic [10:0] ctrl_r, ctrl_nxt;
  logic [13:0] bank1_r, bank1_nxt;
  logic [13:0] bank2_r, bank2_nxt;
  logic        relock_r, relock_nxt;
  logic [31:0] rdata_nxt;
  scc_state_e  state_r, state_nxt;
  logic [6:0]  band_r, band_nxt;
  logic [1:0]  osc_r, osc_nxt;
  logic [3:0]  settle_r, settle_nxt;
  logic        fail_r, fail_nxt;
  logic        ce_q_r;
  logic        lock_meta_r;
  logic        lock_sync_r, lock_sync_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic        slow_r, slow_nxt;
  logic [5:0]  cp_r, cp_nxt;
  logic [2:0]  osc_hot;
  logic        ce_eff, mode_eff, single, launch, bank_two;
  logic [13:0] bank_act;
  logic        m1_nxt, m2_nxt, lock_nxt;

  // Comparison clock from the reference divider
  assign tk.ratio = ctrl_r[CTL_REFDIV_LSB +: 3];
  scc_ref_div u_ref_div (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .tk         (tk)
  );

  // Pin or software control of enable and mode
  assign single   = ctrl_r[CTL_SINGLE];
  assign ce_eff   = ctrl_r[CTL_SWCTL] ? ctrl_r[CTL_CE] : chip_enable_line_in;
  assign mode_eff = ctrl_r[CTL_SWCTL] ? ctrl_r[CTL_MODE] : mode_in;
  assign bank_two = single | mode_eff;
  assign bank_act = bank_two ? bank2_r : bank1_r;
  assign launch   = ce_eff & (~ce_q_r | relock_r);

  // Register writes and read data; relock pending bit set wins over its clear
  always_comb begin
    ctrl_nxt   = ctrl_r;
    bank1_nxt  = bank1_r;
    bank2_nxt  = bank2_r;
    relock_nxt = relock_r & ~launch;
    rdata_nxt  = 32'h0000_0000;
    if (wr_in) begin
      if (addr_in == ADDR_CTRL) begin
        ctrl_nxt = wdata_in[10:0];
        ctrl_nxt[CTL_RELOCK] = 1'b0;
        if (wdata_in[CTL_RELOCK]) relock_nxt = 1'b1;
      end else if (addr_in == ADDR_BANK1) begin
        bank1_nxt = wdata_in[13:0];
      end else if (addr_in == ADDR_BANK2) begin
        bank2_nxt = wdata_in[13:0];
      end
    end
    if (rd_in) begin
      if (addr_in == ADDR_CTRL) begin
        rdata_nxt[10:0] = ctrl_r;
        rdata_nxt[CTL_RELOCK] = relock_r;
      end else if (addr_in == ADDR_BANK1) begin
        rdata_nxt[13:0] = bank1_r;
      end else if (addr_in == ADDR_BANK2) begin
        rdata_nxt[13:0] = bank2_r;
      end else if (addr_in == ADDR_READBACK) begin
        rdata_nxt[RB_BAND_LSB +: 7] = band_r;
        rdata_nxt[RB_FAIL]          = fail_r;
        rdata_nxt[RB_LOCK]          = lock_flag_out;
        rdata_nxt[RB_OSC_LSB +: 2]  = osc_r;
        rdata_nxt[RB_BUSY]          = (state_r != ST_IDLE) && (state_r != ST_ACQ);
        rdata_nxt[RB_SLOW]          = slow_r;
        rdata_nxt[RB_CP_LSB +: 6]   = cp_r;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r   <= CTRL_RESET;
      bank1_r  <= BANK_RESET;
      bank2_r  <= BANK_RESET;
      relock_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      bank1_r  <= bank1_nxt;
      bank2_r  <= bank2_nxt;
      relock_r <= relock_nxt;
    end
  end

  // Calibration sequencer; launch restarts it even mid-search
  always_comb begin
    state_nxt  = state_r;
    band_nxt   = band_r;
    osc_nxt    = osc_r;
    settle_nxt = settle_r;
    fail_nxt   = fail_r;
    if (!ce_eff) begin
      state_nxt = ST_IDLE;
    end else if (launch) begin
      state_nxt = ST_OSC;
    end else if (tk.tick) begin
      case (state_r)
        ST_OSC: begin
          // Oscillator range from the programmed integer divide
          if (bank_n(bank_act) >= N_HIGH)     osc_nxt = OSC_HIGH;
          else if (bank_n(bank_act) >= N_MID) osc_nxt = OSC_MID;
          else                                osc_nxt = OSC_LOW;
          band_nxt   = BAND_MIN;
          settle_nxt = SETTLE_TICKS;
          state_nxt  = ST_SETTLE;
        end
        ST_SETTLE: begin
          if (settle_r == 4'h0) state_nxt = ST_CHECK;
          else                  settle_nxt = settle_r - 4'h1;
        end
        ST_CHECK: begin
          // Still fast: connect one more capacitance step
          if (osc_above_target_in && band_r != BAND_MAX) begin
            band_nxt   = band_r + 7'h01;
            settle_nxt = SETTLE_TICKS;
            state_nxt  = ST_SETTLE;
          end else begin
            fail_nxt  = (band_r == BAND_MIN) || (band_r == BAND_MAX);
            state_nxt = ST_ACQ;
          end
        end
        ST_ACQ:  state_nxt = ST_ACQ;
        ST_IDLE: state_nxt = ST_IDLE;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r  <= ST_IDLE;
      band_r   <= BAND_MIN;
      osc_r    <= OSC_LOW;
      settle_r <= 4'h0;
      fail_r   <= 1'b0;
      ce_q_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      band_r   <= band_nxt;
      osc_r    <= osc_nxt;
      settle_r <= settle_nxt;
      fail_r   <= fail_nxt;
      ce_q_r   <= ce_eff;
    end
  end

  // Lock window sync: first stage feeds only the tick-enabled second stage
  always_comb begin
    lock_sync_nxt = tk.tick ? lock_meta_r : lock_sync_r;
    lock_nxt      = lock_sync_r & (state_r == ST_ACQ);
    wait_nxt      = wait_r;
    slow_nxt      = slow_r;
    if (launch) begin
      wait_nxt = 16'h0000;
      slow_nxt = 1'b0;
    end else if (state_r == ST_ACQ && !lock_sync_r && !slow_r) begin
      // Lock budget overrun is flagged, not acted on
      if (wait_r >= 16'(LOCK_WAIT_CYCLES - 1)) slow_nxt = 1'b1;
      else                                      wait_nxt = wait_r + 16'h0001;
    end
    // Higher band means lower oscillator gain, so less pump current
    cp_nxt = ctrl_r[CTL_LFCAL] ? CP_MAX - {1'b0, band_r[6:2]} : CP_DEF;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
      wait_r      <= 16'h0000;
      slow_r      <= 1'b0;
      cp_r        <= CP_DEF;
    end else begin
      lock_meta_r <= lock_window_in;
      lock_sync_r <= lock_sync_nxt;
      wait_r      <= wait_nxt;
      slow_r      <= slow_nxt;
      cp_r        <= cp_nxt;
    end
  end

  // Mixer routing table
  always_comb begin
    m1_nxt = 1'b0;
    m2_nxt = 1'b0;
    if (ce_eff) begin
      if (single) begin
        m2_nxt = 1'b1;
      end else if (ctrl_r[CTL_FULL_DUPLEX_SELECT]) begin
        m1_nxt = 1'b1;
        m2_nxt = 1'b1;
      end else begin
        m1_nxt = ~mode_eff;
        m2_nxt = mode_eff;
      end
    end
  end

  // Oscillator one-hot select
  generate
    for (genvar i = 0; i < 3; i++) begin : g_osc
      assign osc_hot[i] = (osc_r == 2'(i)) & ce_eff;
    end
  endgenerate

  // Output flops so every pin is registered
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out               <= 32'h0000_0000;
      analog_power_up_out     <= 1'b0;
      osc_sel_out             <= 3'h0;
      band_out                <= BAND_MIN;
      band_search_out         <= 1'b0;
      loop_acquire_out        <= 1'b0;
      lo_output_divider_out   <= LO_OUTPUT_DIVIDER_MIN;
      prescaler_div_out       <= PRESC_LOW;
      n_int_out               <= 11'h000;
      cp_current_out          <= CP_DEF;
      mixer1_en_out           <= 1'b0;
      mixer2_en_out           <= 1'b0;
      bank_two_sel_out        <= 1'b0;
      general_output_four_out <= 1'b0;
      lock_flag_out           <= 1'b0;
    end else begin
      rdata_out               <= rdata_nxt;
      analog_power_up_out     <= ce_eff;
      osc_sel_out             <= osc_hot;
      band_out                <= band_r;
      band_search_out         <= (state_r == ST_SETTLE) || (state_r == ST_CHECK);
      loop_acquire_out        <= (state_r == ST_ACQ);
      lo_output_divider_out   <= bank_div(bank_act);
      prescaler_div_out       <= (osc_r == OSC_HIGH) ? PRESC_HIGH : PRESC_LOW;
      n_int_out               <= bank_n(bank_act);
      cp_current_out          <= cp_r;
      mixer1_en_out           <= m1_nxt;
      mixer2_en_out           <= m2_nxt;
      bank_two_sel_out        <= bank_two;
      general_output_four_out <= ctrl_r[CTL_GPO4LOCK] & lock_nxt;
      lock_flag_out           <= lock_nxt;
    end
  end
endmodule : scc_top
`default_nettype wire

// ### testbench/scc_top_asserts.sv
// Purpose: Port-level checks of the calibration control block
// Assumes: One mclk_in domain, reference divide set by the bench
// Notes:   Bound to scc_top below the module
`timescale 1ns/100ps
`default_nettype none
module scc_top_asserts
  import scc_pkg::*;
#(
  parameter int LOCK_WAIT_CYCLES = 20
) (
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  addr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        lock_window_in,
  input wire logic        analog_power_up_out,
  input wire logic [2:0]  osc_sel_out,
  input wire logic [6:0]  band_out,
  input wire logic        band_search_out,
  input wire logic        loop_acquire_out,
  input wire logic [2:0]  lo_output_divider_out,
  input wire logic [2:0]  prescaler_div_out,
  input wire logic        mixer1_en_out,
  input wire logic        mixer2_en_out,
  input wire logic        bank_two_sel_out,
  input wire logic        general_output_four_out,
  input wire logic        lock_flag_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // One capacitance step inside a search
  sequence sq_band_step;
    band_search_out && $past(band_search_out) && $changed(band_out);
  endsequence
  // Readback read taken after a finished search
  sequence sq_rb_done;
    $past(rd_in && addr_in == ADDR_READBACK && loop_acquire_out);
  endsequence
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside the answer cycle");
  a_fail_code: assert property (sq_rb_done |-> rdata_out[7] ==
    (rdata_out[6:0] == BAND_MIN || rdata_out[6:0] == BAND_MAX))
    else $error("fail flag does not match band");
  a_band_step: assert property (sq_band_step |-> band_out == $past(band_out) + 7'h01)
    else $error("band moved by other than one step");
  a_search_acq: assert property (!(band_search_out && loop_acquire_out))
    else $error("acquire during band search");
  a_band_hold: assert property (loop_acquire_out && $past(loop_acquire_out) |-> $stable(band_out))
    else $error("band changed after search");
  a_lock_acq: assert property (lock_flag_out |-> loop_acquire_out || $past(loop_acquire_out))
    else $error("lock flag outside acquire");
  a_lock_sync: assert property ($rose(lock_window_in) && !lock_flag_out |=> !lock_flag_out)
    else $error("lock flag not synchronised");
  a_gpo_lock: assert property (general_output_four_out |-> lock_flag_out)
    else $error("output four without lock");
  a_half_bank: assert property ((mixer1_en_out ^ mixer2_en_out) |-> bank_two_sel_out == mixer2_en_out)
    else $error("bank does not follow mixer");
  a_idle_off: assert property (!analog_power_up_out [*2] |->
    !band_search_out && !loop_acquire_out && !mixer1_en_out && !mixer2_en_out)
    else $error("activity while disabled");
  a_osc_range: assert property ($onehot0(osc_sel_out) &&
    lo_output_divider_out inside {[LO_OUTPUT_DIVIDER_MIN:LO_OUTPUT_DIVIDER_MAX]})
    else $error("oscillator or divider out of range");
  // Select lines go dark when disabled while the prescaler keeps its last choice
  a_presc_osc: assert property (analog_power_up_out |->
    prescaler_div_out == (osc_sel_out[2] ? PRESC_HIGH : PRESC_LOW))
    else $error("prescaler does not match oscillator");
endmodule : scc_top_asserts
bind scc_top scc_top_asserts #(.LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)) u_scc_top_asserts (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .lock_window_in(lock_window_in),
  .analog_power_up_out(analog_power_up_out), .osc_sel_out(osc_sel_out),
  .band_out(band_out), .band_search_out(band_search_out),
  .loop_acquire_out(loop_acquire_out), .lo_output_divider_out(lo_output_divider_out),
  .prescaler_div_out(prescaler_div_out), .mixer1_en_out(mixer1_en_out),
  .mixer2_en_out(mixer2_en_out), .bank_two_sel_out(bank_two_sel_out),
  .general_output_four_out(general_output_four_out), .lock_flag_out(lock_flag_out)
);
`default_nettype wire

// ### testbench/scc_osc_model.sv
// Purpose: Behavioural oscillator and tuning-voltage comparators
// Assumes: Target band set by the bench
// Notes:   Window answer is held off by the bench to model no lock
`timescale 1ns/100ps
`default_nettype none
module scc_osc_model (
  input  wire logic       mclk_in,
  input  wire logic [6:0] band_in,
  input  wire logic       acquire_in,
  input  wire logic [6:0] target_in,
  input  wire logic       window_ok_in,
  output logic            above_out,
  output logic            window_out
);
  // Too fast until enough capacitance is switched in
  assign above_out = (band_in < target_in);
  // Tuning voltage enters the window a cycle after the loop closes
  initial window_out = 1'b0;
  always @(posedge mclk_in) window_out <= acquire_in & window_ok_in;
endmodule : scc_osc_model
`default_nettype wire

// ### testbench/synth_calibration_control_tb.sv
// Purpose: Self-checking bench for the calibration control block
// Assumes: Reference divide 3, so the sequencer steps every third cycle
// Notes:   Read results are checked from a queue of notes
`timescale 1ns/100ps
`default_nettype none
module synth_calibration_control_tb;
  import scc_pkg::*;
  logic        mclk_in, reset_n_in, wr_in, rd_in, chip_enable_line_in, mode_in;
  logic        above, window, window_ok, rd_q, s, fd, md;
  logic [3:0]  addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [6:0]  band_out, target;
  logic        search, acq, m1, m2, b2, gpo, lock;
  logic [7:0]  seed;
  logic [10:0] n_int;
  logic [2:0]  lodiv;
  logic [5:0]  cp_exp;
  logic [31:0] rb_exp;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [6:0]  tgt[4] = '{7'h00, 7'h7F, 7'h01, 7'h7E};
  int          num_errors, cmp_count;

  scc_top #(.LOCK_WAIT_CYCLES(20)) u_scc_top (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .chip_enable_line_in(chip_enable_line_in), .mode_in(mode_in),
    .osc_above_target_in(above), .lock_window_in(window), .analog_power_up_out(),
    .osc_sel_out(), .band_out(band_out), .band_search_out(search), .loop_acquire_out(acq),
    .lo_output_divider_out(lodiv), .prescaler_div_out(), .n_int_out(n_int), .cp_current_out(),
    .mixer1_en_out(m1), .mixer2_en_out(m2), .bank_two_sel_out(b2),
    .general_output_four_out(gpo), .lock_flag_out(lock));
  scc_osc_model u_scc_osc_model (.mclk_in(mclk_in), .band_in(band_out), .acquire_in(acq),
    .target_in(target), .window_ok_in(window_ok), .above_out(above), .window_out(window));

  // 125 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("compares=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask : wr_reg

  // Note the expected word and mask; the monitor compares later
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk_in);
    rd_in   <= 1'b0;
  endtask : rd_reg

  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_acq(input logic lvl);
    int n;
    n = 0;
    while (acq !== lvl && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n == 3000) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_acq

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_in) rd_q <= rd_in;
  always @(negedge mclk_in) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else chk(rdata_out & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // Main sequence
  initial begin
    {reset_n_in, wr_in, rd_in, chip_enable_line_in, mode_in} = 5'h00;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    window_ok = 1'b1;
    target = 7'h00;
    seed = 8'h61;
    num_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd_reg(ADDR_CTRL, 32'h080, 32'hFFFFFFFF);
    rd_reg(4'h2, 32'h0, 32'hFFFFFFFF);
    wr_reg(ADDR_BANK1, 32'hFFFFFFFF);
    rd_reg(ADDR_BANK1, 32'h3FFF, 32'hFFFFFFFF);
    // Divide by 3 keeps the comparison rate under its limit
    wr_reg(ADDR_CTRL, 32'h180);
    // Pin launch, then relock launches; extreme and random targets
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      target <= (i < 4) ? tgt[i] : 7'(8'h01 + seed % 8'd126);
      window_ok <= (i != 2);
      if (i == 0) chip_enable_line_in <= 1'b1;
      else wr_reg(ADDR_CTRL, 32'h1E2);
      wait_acq(1'b0);
      wait_acq(1'b1);
      repeat (10) @(posedge mclk_in);
      // Loop calibration is on for relock passes only; bank one picks the high range
      cp_exp = (i > 0) ? CP_MAX - {1'b0, target[6:2]} : CP_DEF;
      rb_exp = {13'h0, cp_exp, 2'b00, OSC_HIGH, window_ok,
        target == BAND_MIN || target == BAND_MAX, target};
      rd_reg(ADDR_READBACK, rb_exp, 32'h7FFFF);
      rd_reg(ADDR_CTRL, 32'h0, 32'h2);
      chk({31'h0, gpo}, {31'h0, window_ok && i > 0});
      // No lock at all: the overrun flag must come up after the budget
      if (i == 2) begin
        repeat (20) @(posedge mclk_in);
        rd_reg(ADDR_READBACK, 32'h1 << RB_SLOW, 32'h1 << RB_SLOW);
      end
    end
    // Mixer and bank routing; last pass under software control
    for (int k = 0; k < 9; k++) begin
      s = (k < 8) & k[2];
      fd = (k < 8) & k[1];
      md = (k == 8) | k[0];
      mode_in <= (k < 8) & k[0];
      wr_reg(ADDR_CTRL, (k < 8) ? (32'h1C0 | (fd << 3) | (s << 10)) : 32'h1D5);
      repeat (3) @(posedge mclk_in);
      chk({29'h0, m1, m2, b2}, {29'h0, !s & (fd | !md), s | fd | md, s | md});
      chk({18'h0, lodiv, n_int},
        (s | md) ? {18'h0, BANK_RESET} : {18'h0, LO_OUTPUT_DIVIDER_MAX, 11'h7FF});
    end
    // Reset in mid search
    target <= 7'h7F;
    wr_reg(ADDR_CTRL, 32'h1D7);
    repeat (30) @(posedge mclk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk({28'h0, search, acq, lock, m2}, 32'h0);
    reset_n_in <= 1'b1;
    rd_reg(ADDR_CTRL, 32'h080, 32'hFFFFFFFF);
    @(posedge mclk_in);
    report_and_stop();
  end
endmodule : synth_calibration_control_tb
`default_nettype wire
